// >>> design/asc_defs.vh
/*
 converter control constants: register offsets, field positions, reset
 values and timing counts. assumes inclusion by bare name.
*/
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH

// register byte addresses on the apb bus
`define ASC_OFS_CTRL0     12'h000
`define ASC_OFS_CTRL1     12'h004
`define ASC_OFS_CTRL2     12'h008
`define ASC_OFS_RES_HI    12'h00C
`define ASC_OFS_RES_LO    12'h010
`define ASC_OFS_IRQ       12'h014
`define ASC_OFS_BANDGAP   12'h018

// ctrl0 fields
`define ASC_C0_START      7
`define ASC_C0_BUSY       6
`define ASC_C0_PWR        5
`define ASC_C0_FMT        4
// ctrl1 fields
`define ASC_C1_SRC_HI     7
`define ASC_C1_SRC_LO     4
// ctrl2 fields
`define ASC_C2_AMP_EN     7
`define ASC_C2_AMP_IN     4
// irq register fields
`define ASC_IRQ_FLAG      0
`define ASC_IRQ_EN        1
`define ASC_IRQ_GLOBAL    2

// reset values
`define ASC_RST_BYTE      8'h00
`define ASC_RST_RESULT    12'h000

// mask of implemented bits
`define ASC_C1_MASK       8'hF7
`define ASC_C2_MASK       8'h9F

// conversion timing in conversion clock periods
`define ASC_SAMPLE_PERIODS   5'd4
`define ASC_CONVERT_PERIODS  5'd12
`define ASC_TOTAL_PERIODS    5'd16

`endif

// >>> design/asc_ctrl.v
/*
 converter sequencing control: apb register file, start detection, busy
 flag, conversion clock divider, input/reference routing and result
 registers. assumes the analog converter supplies a 12-bit result that is
 stable by the last conversion clock period, and an outside interrupt
 controller takes the request outputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.vh"

// Contract
// - conversion starts when the start bit is written high, then low.
// - busy flag sets once a conversion starts and stays high throughout.
// - busy flag clears to zero when the conversion ends.
// - completion sets the interrupt request flag regardless of enable.
// - with local and global enables set, completion raises interrupt out.
// - conversion clock is system clock divided by 1 to 128 by code.
// - source codes 0000, 0100, 11xx route the chosen external pin.
// - channel codes 0-7 pick pins 0-7; codes 8-15 leave input floating.
// - internal source codes disconnect all external channels.
// - internal codes pick supply fractions, amplified reference, ground.
// - two-bit gain field and amplifier enable control the amplifier.
// - amplifier input is the reference pin or the bandgap voltage.
// - internal reference selection switches off external reference pins; amp input bit 0 still connects the pin.
// - pin used as converter input drops its function and pull-high.
// - pin used as converter input ignores its direction setting.
// - a conversion is 4 sampling plus 12 converting clock periods.
// - result registers hold their contents while power is off.
// - format bit splits result as 11:4/3:0 or 11:8/7:0.
// - reference select: 00 supply, 01 reference pin, 1x amplified.
module asc_ctrl #(
   parameter N_PINS = 8
) (
   // clock and reset
   input  wire              i_clk,
   input  wire              i_rstn,
   // apb slave
   input  wire              i_psel,
   input  wire              i_penable,
   input  wire              i_pwrite,
   input  wire [11:0]       i_paddr,
   input  wire [31:0]       i_pwdata,
   output wire              o_pready,
   output reg  [31:0]       o_prdata,
   output wire              o_pslverr,
   // analog converter core
   input  wire [11:0]       i_conv_data,
   output reg               o_conv_sample,
   output reg               o_conv_active,
   output reg               o_conv_clk_en,
   output reg               o_conv_power,
   // input routing
   output reg  [N_PINS-1:0] o_chan_connect,
   output reg  [3:0]        o_internal_src,
   // pin sharing
   input  wire [N_PINS-1:0] i_pin_analog_sel,
   output reg  [N_PINS-1:0] o_pin_func_dis,
   output reg  [N_PINS-1:0] o_pin_pullup_dis,
   output reg  [N_PINS-1:0] o_pin_dir_override,
   // reference and amplifier
   output reg  [1:0]        o_ref_sel,
   output reg               o_ref_pin_connect,
   output reg               o_amp_ref_pin_connect,
   output reg               o_amp_enable,
   output reg  [1:0]        o_amp_gain,
   output reg               o_amp_in_bandgap,
   output reg               o_bandgap_enable,
   // interrupt request
   output reg               o_irq_flag,
   output reg               o_irq
);

   localparam ST_IDLE   = 2'd0;
   localparam ST_SAMPLE = 2'd1;
   localparam ST_CONV   = 2'd2;

   reg  [7:0]  ctrl0_reg;
   reg  [7:0]  ctrl1_reg;
   reg  [7:0]  ctrl2_reg;
   reg         irq_en_reg;
   reg         irq_gen_reg;
   reg  [11:0] result_reg;
   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg  [4:0]  period_reg;
   reg  [6:0]  div_reg;
   reg         armed_reg;
   reg  [31:0] rdata_mux;

   wire        wr_en;
   wire        rd_en;
   wire [3:0]  src_sel;
   wire [3:0]  chan_sel;
   wire        external_src;
   wire        tick;
   wire        start_go;
   wire        done;

   // one decode shared by channel switch and internal source routing
   function is_external;
      input [3:0] code;
      begin
         is_external = (code == 4'h0) || (code == 4'h4) ||
                       (code[3:2] == 2'b11);
      end
   endfunction

   // apb: zero wait states, no error responses; unmapped reads give zero
   assign o_pready  = 1'b1;
   assign o_pslverr = 1'b0;
   assign wr_en     = i_psel & i_penable & i_pwrite;
   assign rd_en     = i_psel & ~i_pwrite;

   assign src_sel      = ctrl1_reg[`ASC_C1_SRC_HI:`ASC_C1_SRC_LO];
   assign chan_sel     = ctrl0_reg[3:0];
   assign external_src = is_external(src_sel);

   // divider: tick every 2^code system cycles
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         div_reg <= 7'd0;
      end else if (state_reg == ST_IDLE) begin
         div_reg <= 7'd0;
      end else begin
         div_reg <= div_reg + 7'd1;
      end
   end
   assign tick = ((div_reg & ((7'd1 << ctrl1_reg[2:0]) - 7'd1)) ==
                  ((7'd1 << ctrl1_reg[2:0]) - 7'd1));

   // start is the falling edge of the start bit after it was high
   assign start_go = wr_en && (i_paddr == `ASC_OFS_CTRL0) && armed_reg &&
                     !i_pwdata[`ASC_C0_START] && ctrl0_reg[`ASC_C0_PWR];
   assign done = (state_reg == ST_CONV) && tick &&
                 (period_reg == `ASC_TOTAL_PERIODS - 5'd1);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start_go) begin
               state_next = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (tick && period_reg == `ASC_SAMPLE_PERIODS - 5'd1) begin
               state_next = ST_CONV;
            end
         end
         ST_CONV: begin
            if (done) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (!ctrl0_reg[`ASC_C0_PWR]) begin
         state_next = ST_IDLE;
      end
   end

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg  <= ST_IDLE;
         period_reg <= 5'd0;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_IDLE) begin
            period_reg <= 5'd0;
         end else if (tick) begin
            period_reg <= period_reg + 5'd1;
         end
      end
   end

   // registers; busy bit is hardware owned
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl0_reg   <= `ASC_RST_BYTE;
         ctrl1_reg   <= `ASC_RST_BYTE;
         ctrl2_reg   <= `ASC_RST_BYTE;
         irq_en_reg  <= 1'b0;
         irq_gen_reg <= 1'b0;
         o_irq_flag  <= 1'b0;
         o_bandgap_enable <= 1'b0;
         result_reg  <= `ASC_RST_RESULT;
         armed_reg   <= 1'b0;
      end else begin
         if (wr_en) begin
            case (i_paddr)
               `ASC_OFS_CTRL0: begin
                  ctrl0_reg[7]   <= i_pwdata[7];
                  ctrl0_reg[5:0] <= i_pwdata[5:0];
                  armed_reg      <= i_pwdata[`ASC_C0_START];
               end
               `ASC_OFS_CTRL1: ctrl1_reg <= i_pwdata[7:0] & `ASC_C1_MASK;
               `ASC_OFS_CTRL2: ctrl2_reg <= i_pwdata[7:0] & `ASC_C2_MASK;
               `ASC_OFS_IRQ: begin
                  o_irq_flag  <= i_pwdata[`ASC_IRQ_FLAG];
                  irq_en_reg  <= i_pwdata[`ASC_IRQ_EN];
                  irq_gen_reg <= i_pwdata[`ASC_IRQ_GLOBAL];
               end
               `ASC_OFS_BANDGAP: o_bandgap_enable <= i_pwdata[0];
               default: ;
            endcase
         end
         // busy tracks the sequencer; ctrl0 writes never touch this bit
         ctrl0_reg[`ASC_C0_BUSY] <= (state_next != ST_IDLE);
         if (done) begin
            o_irq_flag <= 1'b1;
            result_reg <= i_conv_data;
         end
      end
   end

   // interrupt line: a one-cycle pulse on completion when enabled
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= done & irq_en_reg & irq_gen_reg;
      end
   end

   // read mux
   always @* begin
      rdata_mux = 32'h0000_0000;
      if (rd_en) begin
         case (i_paddr)
            `ASC_OFS_CTRL0:   rdata_mux[7:0] = ctrl0_reg;
            `ASC_OFS_CTRL1:   rdata_mux[7:0] = ctrl1_reg;
            `ASC_OFS_CTRL2:   rdata_mux[7:0] = ctrl2_reg;
            `ASC_OFS_RES_HI:  rdata_mux[7:0] = ctrl0_reg[`ASC_C0_FMT] ?
                                 {4'h0, result_reg[11:8]} :
                                 result_reg[11:4];
            `ASC_OFS_RES_LO:  rdata_mux[7:0] = ctrl0_reg[`ASC_C0_FMT] ?
                                 result_reg[7:0] :
                                 {4'h0, result_reg[3:0]};
            `ASC_OFS_IRQ:     rdata_mux[2:0] = {irq_gen_reg, irq_en_reg,
                                                o_irq_flag};
            `ASC_OFS_BANDGAP: rdata_mux[0]   = o_bandgap_enable;
            default:          rdata_mux      = 32'h0000_0000;
         endcase
      end
   end

   // read data is captured in the setup cycle, so it stands from a flop
   // through the whole access phase; it shows the state before that edge
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_prdata <= 32'h0000_0000;
      end else if (rd_en && !i_penable) begin
         o_prdata <= rdata_mux;
      end
   end

   // analog controls, registered
   integer k;
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_conv_sample  <= 1'b0;
         o_conv_active  <= 1'b0;
         o_conv_clk_en  <= 1'b0;
         o_conv_power   <= 1'b0;
         o_chan_connect <= {N_PINS{1'b0}};
         o_internal_src <= 4'h0;
         o_pin_func_dis <= {N_PINS{1'b0}};
         o_pin_pullup_dis   <= {N_PINS{1'b0}};
         o_pin_dir_override <= {N_PINS{1'b0}};
         o_ref_sel      <= 2'b00;
         o_ref_pin_connect     <= 1'b0;
         o_amp_ref_pin_connect <= 1'b0;
         o_amp_enable   <= 1'b0;
         o_amp_gain     <= 2'b00;
         o_amp_in_bandgap <= 1'b0;
      end else begin
         o_conv_sample <= (state_next == ST_SAMPLE);
         o_conv_active <= (state_next != ST_IDLE);
         o_conv_clk_en <= tick && (state_reg != ST_IDLE);
         o_conv_power  <= ctrl0_reg[`ASC_C0_PWR];
         o_internal_src <= external_src ? 4'h0 : src_sel;
         for (k = 0; k < N_PINS; k = k + 1) begin
            o_chan_connect[k] <= external_src && !chan_sel[3] &&
                                 (chan_sel[2:0] == k);
         end
         o_pin_func_dis     <= i_pin_analog_sel;
         o_pin_pullup_dis   <= i_pin_analog_sel;
         o_pin_dir_override <= i_pin_analog_sel;
         o_ref_sel <= ctrl2_reg[3:2];
         o_ref_pin_connect <= (ctrl2_reg[3:2] == 2'b01);
         o_amp_enable <= ctrl2_reg[`ASC_C2_AMP_EN];
         o_amp_gain   <= ctrl2_reg[1:0];
         o_amp_in_bandgap <= ctrl2_reg[`ASC_C2_AMP_IN];
         o_amp_ref_pin_connect <= !ctrl2_reg[`ASC_C2_AMP_IN];
      end
   end

endmodule // asc_ctrl
`default_nettype wire

// >>> test/asc_ctrl_props.sv
/*
 checker for the converter control block: sequencing, interrupt and
 routing relations seen at the ports. assumes it is bound into asc_ctrl.
*/
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_props #(
   parameter N_PINS = 8
) (
   input wire logic              i_clk, i_rstn, o_conv_active,
   input wire logic              o_conv_sample, o_conv_clk_en, o_conv_power,
   input wire logic              o_irq_flag, o_irq, o_ref_pin_connect,
   input wire logic [1:0]        o_ref_sel,
   input wire logic [3:0]        o_internal_src,
   input wire logic [N_PINS-1:0] o_chan_connect, i_pin_analog_sel,
   input wire logic [N_PINS-1:0] o_pin_func_dis, o_pin_pullup_dis,
   input wire logic [N_PINS-1:0] o_pin_dir_override
);
   int cnt;
   // counts conversion clock periods of the running conversion only
   always @(posedge i_clk or negedge i_rstn)
      if (!i_rstn) cnt <= 0;
      else if (!o_conv_active) cnt <= 0;
      else if (o_conv_clk_en) cnt <= cnt + 1;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // a power-off abort drops power too, so it is not a completion
   sequence s_done; $fell(o_conv_active) && o_conv_power; endsequence
   sequence s_sample; o_conv_sample; endsequence
   // sampling hands over to converting with the conversion still active
   sequence s_sample_end; $fell(o_conv_sample) && o_conv_active; endsequence
   done_sets_flag_a: assert property (s_done |-> o_irq_flag)
      else $error("completion left the request flag low");
   irq_pulse_a: assert property (o_irq |=> !o_irq)
      else $error("interrupt output longer than one cycle");
   irq_cause_a: assert property (o_irq |-> o_irq_flag &&
      $fell(o_conv_active)) else $error("interrupt without a request flag");
   chan_onehot_a: assert property ($onehot0(o_chan_connect))
      else $error("more than one channel switch closed");
   chan_internal_a: assert property (o_internal_src != 4'h0 |->
      o_chan_connect == '0) else $error("external pin joined to internal");
   ref_pin_a: assert property (o_ref_pin_connect |-> o_ref_sel == 2'b01)
      else $error("reference pin connected while not selected");
   sample_in_conv_a: assert property (s_sample |-> o_conv_active)
      else $error("sampling outside a conversion");
   busy_powered_a: assert property (o_conv_active |-> o_conv_power)
      else $error("busy while the converter is off");
   period_count_a: assert property (cnt <= 15)
      else $error("conversion ran past its period count");
   sample_len_a: assert property (s_sample_end |-> cnt == 3)
      else $error("sampling phase not four conversion clocks");
   conv_len_a: assert property (s_done |-> cnt == 15)
      else $error("conversion not sixteen conversion clocks");
   pin_copy_a: assert property (1 |=> o_pin_func_dis ==
      $past(i_pin_analog_sel) && o_pin_pullup_dis == $past(i_pin_analog_sel))
      else $error("pin function or pull-high not released");
   pin_dir_a: assert property (1 |=>
      o_pin_dir_override == $past(i_pin_analog_sel))
      else $error("pin direction not overridden");
   cover property (s_done);
endmodule // asc_ctrl_props
bind asc_ctrl asc_ctrl_props #(.N_PINS(N_PINS)) u_props (
   .i_clk(i_clk), .i_rstn(i_rstn), .o_conv_active(o_conv_active),
   .o_conv_sample(o_conv_sample), .o_conv_clk_en(o_conv_clk_en),
   .o_conv_power(o_conv_power), .o_irq_flag(o_irq_flag), .o_irq(o_irq),
   .o_ref_pin_connect(o_ref_pin_connect), .o_ref_sel(o_ref_sel),
   .o_internal_src(o_internal_src), .o_chan_connect(o_chan_connect),
   .i_pin_analog_sel(i_pin_analog_sel), .o_pin_func_dis(o_pin_func_dis),
   .o_pin_pullup_dis(o_pin_pullup_dis),
   .o_pin_dir_override(o_pin_dir_override));
`default_nettype wire

// >>> test/asc_core_model.sv
/*
 behavioural analog core: holds the bench's level while converting.
 assumes the bench sets the level before the conversion starts.
*/
`timescale 1ns/1ps
`default_nettype none
module asc_core_model (
   input  wire logic        i_clk,
   input  wire logic        i_conv_active,
   input  wire logic [11:0] i_level,
   output var  logic [11:0] o_data
);
   initial o_data = 12'h5A5;
   // idle output toggles so a stale sample can never pass for a result
   always @(posedge i_clk) o_data <= i_conv_active ? i_level : ~o_data;
endmodule // asc_core_model
`default_nettype wire

// >>> test/tb_top.sv
/*
 self-checking bench for asc_ctrl: apb master, routing and conversion
 scenarios. assumes the analog core model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
   $display("FAIL %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
   logic i_clk = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic [11:0] i_paddr = 0, level = 0, val;
   logic [31:0] i_pwdata = 0, rd, r, seed = 38;
   logic [7:0]  i_pin_analog_sel = 0, w, c0;
   wire o_pready, o_pslverr, o_conv_sample, o_conv_active, o_conv_clk_en;
   wire o_conv_power, o_ref_pin_connect, o_amp_ref_pin_connect, o_irq;
   wire o_amp_enable, o_amp_in_bandgap, o_bandgap_enable, o_irq_flag, ext;
   wire [31:0] o_prdata;
   wire [11:0] i_conv_data;
   wire [7:0] o_chan_connect, o_pin_func_dis, o_pin_pullup_dis;
   wire [7:0] o_pin_dir_override;
   wire [3:0] o_internal_src;
   wire [1:0] o_ref_sel, o_amp_gain;
   int fails = 0, total_checks = 0, n;
   asc_ctrl #(.N_PINS(8)) dut (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
      .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_conv_data(i_conv_data),
      .o_conv_sample(o_conv_sample), .o_conv_active(o_conv_active),
      .o_conv_clk_en(o_conv_clk_en), .o_conv_power(o_conv_power),
      .o_chan_connect(o_chan_connect), .o_internal_src(o_internal_src),
      .i_pin_analog_sel(i_pin_analog_sel), .o_pin_func_dis(o_pin_func_dis),
      .o_pin_pullup_dis(o_pin_pullup_dis), .o_ref_sel(o_ref_sel),
      .o_pin_dir_override(o_pin_dir_override), .o_irq(o_irq),
      .o_ref_pin_connect(o_ref_pin_connect), .o_amp_enable(o_amp_enable),
      .o_amp_ref_pin_connect(o_amp_ref_pin_connect), .o_irq_flag(o_irq_flag),
      .o_amp_gain(o_amp_gain), .o_amp_in_bandgap(o_amp_in_bandgap),
      .o_bandgap_enable(o_bandgap_enable));
   asc_core_model core (.i_clk(i_clk), .i_conv_active(o_conv_active),
      .i_level(level), .o_data(i_conv_data));
   initial forever #2.5 i_clk = ~i_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task conclude();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clk);
      i_psel <= 1; i_penable <= 0; i_pwrite <= wr; i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk) i_penable <= 1;
      k = 0;
      do begin @(posedge i_clk); k++; end while (o_pready !== 1'b1 && k < 50);
      if (o_pready !== 1'b1) begin fails++; conclude(); end
      rd = o_prdata;
      i_psel <= 0; i_penable <= 0;
   endtask
   // model of the source decode: external for 0000, 0100 and 11xx
   assign ext = r[11:8] == 4'h0 || r[11:8] == 4'h4 || r[11:10] == 2'b11;
   initial begin
      repeat (16) @(posedge i_clk);
      i_rstn <= 1;
      for (int a = 0; a < 8; a++) begin // 0x1C is unmapped
         apb(0, a * 4, 0); `CHK(rd, 32'h0000_0000) end
      apb(1, `ASC_OFS_CTRL0, 32'h0000_0040); apb(0, `ASC_OFS_CTRL0, 0);
      `CHK(rd, 32'h0000_0000)
      for (int i = 0; i < 16; i++) begin
         r = rnd(); r[11:8] = i;
         @(posedge i_clk) i_pin_analog_sel <= r[23:16];
         apb(1, `ASC_OFS_CTRL1, {24'h0, r[11:4]});
         apb(1, `ASC_OFS_CTRL0, {28'h0, r[3:0]});
         apb(0, `ASC_OFS_CTRL1, 0); #1;
         `CHK(rd[7:0], r[11:4] & `ASC_C1_MASK)
         `CHK(o_chan_connect, (ext && !r[3]) ? 8'h01 << r[2:0] : 8'h00)
         `CHK(o_internal_src, ext ? 4'h0 : r[11:8])
         `CHK(o_pin_func_dis, r[23:16])
      end
      apb(1, `ASC_OFS_BANDGAP, 1); #1; `CHK(o_bandgap_enable, 1'b1)
      for (int i = 0; i < 16; i++) begin
         r = rnd(); w = {r[7:4], i[3:0]};
         apb(1, `ASC_OFS_CTRL2, {24'h0, w}); apb(0, `ASC_OFS_CTRL2, 0); #1;
         `CHK(rd[7:0], w & `ASC_C2_MASK)
         `CHK(o_ref_sel, w[3:2])
         `CHK(o_ref_pin_connect, w[3:2] == 2'b01)
         `CHK(o_amp_ref_pin_connect, !w[4])
         `CHK(o_amp_in_bandgap, w[4])
         `CHK({o_amp_enable, o_amp_gain}, {w[7], w[1:0]})
      end
      // every divider code for coverage; at 200 MHz only 111 is slow enough
      // for the analog side, the rest keep the run short
      for (int d = 0; d < 8; d++) begin
         val = rnd(); level <= val; c0 = d[0] << 4;
         apb(1, `ASC_OFS_CTRL1, d); apb(1, `ASC_OFS_IRQ, d[1] ? 6 : 0);
         apb(1, `ASC_OFS_CTRL0, c0 | 8'h20);
         repeat (8) @(posedge i_clk);
         apb(1, `ASC_OFS_CTRL0, c0 | 8'hA0); #1;
         `CHK(o_conv_active, 1'b0)
         apb(1, `ASC_OFS_CTRL0, c0 | 8'h20); apb(0, `ASC_OFS_CTRL0, 0);
         `CHK(rd[6], 1'b1)
         #1; n = 3; // edges since the start write
         while (o_conv_active === 1'b1 && n < 5000) begin
            @(posedge i_clk); #1; n++; end
         `CHK(n, 16 << d)
         `CHK(o_irq_flag, 1'b1)
         `CHK(o_irq, d[1])
         @(posedge i_clk); #1;
         `CHK(o_irq, 1'b0)
         apb(0, `ASC_OFS_RES_HI, 0);
         `CHK(rd[7:0], d[0] ? {4'h0, val[11:8]} : val[11:4])
         apb(0, `ASC_OFS_RES_LO, 0);
         `CHK(rd[7:0], d[0] ? val[7:0] : {4'h0, val[3:0]})
         apb(1, `ASC_OFS_IRQ, 0); #1; `CHK(o_irq_flag, 1'b0)
         level <= ~val;
         apb(1, `ASC_OFS_CTRL0, c0 | 8'hA0); apb(1, `ASC_OFS_CTRL0, c0 | 8'h20);
         apb(1, `ASC_OFS_CTRL0, c0); @(posedge i_clk); #1;
         `CHK(o_conv_active, 1'b0)
         apb(0, `ASC_OFS_RES_LO, 0);
         `CHK(rd[7:0], d[0] ? val[7:0] : {4'h0, val[3:0]})
         `CHK(o_irq_flag, 1'b0)
      end
      conclude();
   end
   initial begin
      repeat (100000) @(posedge i_clk);
      fails++;
      conclude();
   end
endmodule // tb_top
`default_nettype wire
